/* File: port_stats_pkg.sv */
// Constants shared by the per-port Ethernet statistics block
package port_stats_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_NS      = 50;
    localparam int SECOND_NS     = 1_000_000_000;
    localparam int SECOND_CYCLES = SECOND_NS / CLOCK_NS;

    // ------------------------------------------------------------
    // Frame length limits, FCS in, framing bits out
    // ------------------------------------------------------------
    localparam int LEN_MIN     = 64;
    localparam int LEN_B127    = 127;
    localparam int LEN_B255    = 255;
    localparam int LEN_B511    = 511;
    localparam int LEN_B1023   = 1023;
    localparam int LEN_STD_MAX = 1518;
    localparam int LEN_TAG_MAX = 1522;

    // ------------------------------------------------------------
    // Counter indices into the counter store
    // ------------------------------------------------------------
    localparam int C_OCT      = 0;
    localparam int C_LT64     = 1;
    localparam int C_64       = 2;
    localparam int C_127      = 3;
    localparam int C_255      = 4;
    localparam int C_511      = 5;
    localparam int C_1023     = 6;
    localparam int C_1518     = 7;
    localparam int C_1522     = 8;
    localparam int C_OVER     = 9;
    localparam int C_RX_GOOD  = 10;
    localparam int C_UCAST    = 11;
    localparam int C_MCAST    = 12;
    localparam int C_BCAST    = 13;
    localparam int C_JABBER   = 14;
    localparam int C_FRAG     = 15;
    localparam int C_ALIGN    = 16;
    localparam int C_FCS      = 17;
    localparam int C_OVERRUN  = 18;
    localparam int C_RX_ERR   = 19;
    localparam int C_TX_GOOD  = 20;
    localparam int C_TX_ERR   = 21;
    localparam int C_COLL     = 22;
    localparam int C_TX_BCAST = 23;
    localparam int NUM_CNT    = 24;
    localparam int SEL_W      = 5;

    // ------------------------------------------------------------
    // Elapsed time limits and reset values
    // ------------------------------------------------------------
    localparam int SEC_MAX  = 59;
    localparam int MIN_MAX  = 59;
    localparam int HOUR_MAX = 23;
    localparam int CNT_RST  = 0;

endpackage

/* File: port_stats.sv */
// Per-port Ethernet receive/transmit statistics counters
//
// Overview of operation
// - Add every received octet, bad frames too
// - Count frames under 64 octets in bin
// - Count exactly 64-octet frames in bin
// - One inclusive bin per length up to 1518
// - Count 1519 to 1522 octet frames
// - Count well formed frames over 1522
// - Count every error-free received frame
// - Count good delivered individual-address frames
// - Count good group frames, broadcast excluded
// - Count good broadcast frames separately
// - Jabber: over 1518 with bad FCS
// - Count fragments shorter than 64 octets
// - Alignment: 64-1518, bad FCS, partial octet
// - FCS error: 64-1518, whole octets
// - Count frames dropped by overrun
// - Count received frames with errors
// - Count frames sent out the port
// - Count frames failed by transmit error
// - Accumulate estimate of segment collisions
// - Count broadcast transmit requests always
// - Report active address-table entries
// - Keep days/hours/minutes/seconds since clear
`timescale 1ns/1ns
`default_nettype none

module port_stats
    import port_stats_pkg::*;
#(
    parameter int CNT_W       = 32,
    parameter int LEN_W       = 16,
    parameter int ADDR_W      = 14,
    parameter int SEC_CYCLES  = SECOND_CYCLES
) (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic              rx_done,
    input  wire logic [LEN_W-1:0]  rx_len,
    input  wire logic              rx_fcs_bad,
    input  wire logic              rx_part_octet,
    input  wire logic              rx_sym_err,
    input  wire logic              rx_dst_group,
    input  wire logic              rx_dst_bcast,
    input  wire logic              rx_to_upper,
    input  wire logic              rx_overrun,
    input  wire logic              tx_done,
    input  wire logic              tx_ok,
    input  wire logic              tx_coll,
    input  wire logic [4:0]        tx_coll_num,
    input  wire logic              tx_bcast_req,
    input  wire logic              addr_add,
    input  wire logic              addr_del,
    input  wire logic              clr_req,
    input  wire logic [SEL_W-1:0]  rd_sel,
    output logic [CNT_W-1:0]       rd_data,
    output logic [ADDR_W-1:0]      addr_used,
    output logic [15:0]            up_days,
    output logic [4:0]             up_hours,
    output logic [5:0]             up_mins,
    output logic [5:0]             up_secs
);

    // ------------------------------------------------------------
    // State and constants
    // ------------------------------------------------------------
    typedef logic [NUM_CNT-1:0][CNT_W-1:0] cnt_array_type;

    typedef struct packed {
        cnt_array_type       cnt;
        logic [CNT_W-1:0]    rd_data;
        logic [ADDR_W-1:0]   addr_used;
        logic [31:0]         tick;
        logic [15:0]         days;
        logic [4:0]          hours;
        logic [5:0]          mins;
        logic [5:0]          secs;
    } state_type;

    localparam logic [CNT_W-1:0]  ONE       = CNT_W'(1);
    localparam logic [31:0]       TICK_LAST = 32'(SEC_CYCLES - 1);

    state_type      s_r;
    state_type      s_nxt;
    cnt_array_type  inc;
    logic           rx_good;
    logic           std_len;
    logic           well_formed;

    // Maps a frame length onto the one length bin it falls in, or -1 above 1522
    function automatic int len_bin(input logic [LEN_W-1:0] len);
        int b;
        if (len < LEN_W'(LEN_MIN)) begin
            b = C_LT64;
        end else if (len == LEN_W'(LEN_MIN)) begin
            b = C_64;
        end else if (len <= LEN_W'(LEN_B127)) begin
            b = C_127;
        end else if (len <= LEN_W'(LEN_B255)) begin
            b = C_255;
        end else if (len <= LEN_W'(LEN_B511)) begin
            b = C_511;
        end else if (len <= LEN_W'(LEN_B1023)) begin
            b = C_1023;
        end else if (len <= LEN_W'(LEN_STD_MAX)) begin
            b = C_1518;
        end else if (len <= LEN_W'(LEN_TAG_MAX)) begin
            b = C_1522;
        end else begin
            b = -1;
        end
        return b;
    endfunction

    // ------------------------------------------------------------
    // Frame classification
    // ------------------------------------------------------------
    // A good frame has a sane length and clean FCS and symbols
    assign well_formed = !rx_fcs_bad && !rx_sym_err;
    assign std_len     = rx_len >= LEN_W'(LEN_MIN)
                         && rx_len <= LEN_W'(LEN_STD_MAX);
    assign rx_good     = well_formed
                         && rx_len >= LEN_W'(LEN_MIN)
                         && rx_len <= LEN_W'(LEN_TAG_MAX);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Per-counter increments, then a single adder per counter
    always_comb begin
        int b;
        b     = len_bin(rx_len);
        s_nxt = s_r;
        inc   = '0;
        if (rx_done) begin
            inc[C_OCT] = CNT_W'(rx_len);
            if (b >= 0) begin
                inc[b] = ONE;
            end
            if (rx_len > LEN_W'(LEN_TAG_MAX) && well_formed) begin
                inc[C_OVER] = ONE;
            end
            if (rx_good) begin
                inc[C_RX_GOOD] = ONE;
                if (!rx_dst_group && rx_to_upper) begin
                    inc[C_UCAST] = ONE;
                end
                if (rx_dst_group && !rx_dst_bcast) begin
                    inc[C_MCAST] = ONE;
                end
                if (rx_dst_bcast) begin
                    inc[C_BCAST] = ONE;
                end
            end else begin
                inc[C_RX_ERR] = ONE;
            end
            if (rx_len > LEN_W'(LEN_STD_MAX) && rx_fcs_bad) begin
                inc[C_JABBER] = ONE;
            end
            if (rx_len < LEN_W'(LEN_MIN)) begin
                inc[C_FRAG] = ONE;
            end
            if (std_len && rx_fcs_bad && rx_part_octet) begin
                inc[C_ALIGN] = ONE;
            end
            if (std_len && rx_fcs_bad && !rx_part_octet) begin
                inc[C_FCS] = ONE;
            end
        end
        if (rx_overrun) begin
            inc[C_OVERRUN] = ONE;
        end
        if (tx_done) begin
            inc[C_TX_GOOD] = tx_ok ? ONE : '0;
            inc[C_TX_ERR]  = tx_ok ? '0 : ONE;
        end
        if (tx_coll) begin
            inc[C_COLL] = CNT_W'(tx_coll_num);
        end
        if (tx_bcast_req) begin
            inc[C_TX_BCAST] = ONE;
        end

        // Clear restarts from zero but keeps this cycle's events
        for (int i = 0; i < NUM_CNT; i++) begin
            s_nxt.cnt[i] = (clr_req ? '0 : s_r.cnt[i]) + inc[i];
        end

        // Unmapped selections read as zero
        if (int'(rd_sel) < NUM_CNT) begin
            s_nxt.rd_data = s_r.cnt[rd_sel];
        end else begin
            s_nxt.rd_data = '0;
        end

        // Occupancy saturates; add and remove together cancel
        if (addr_add && !addr_del && s_r.addr_used != '1) begin
            s_nxt.addr_used = s_r.addr_used + ADDR_W'(1);
        end else if (addr_del && !addr_add && s_r.addr_used != '0) begin
            s_nxt.addr_used = s_r.addr_used - ADDR_W'(1);
        end

        // Elapsed time; days wrap after 65535 as a known limit
        if (clr_req) begin
            s_nxt.tick  = '0;
            s_nxt.secs  = '0;
            s_nxt.mins  = '0;
            s_nxt.hours = '0;
            s_nxt.days  = '0;
        end else if (s_r.tick == TICK_LAST) begin
            s_nxt.tick = '0;
            if (s_r.secs != 6'(SEC_MAX)) begin
                s_nxt.secs = s_r.secs + 6'd1;
            end else begin
                s_nxt.secs = '0;
                if (s_r.mins != 6'(MIN_MAX)) begin
                    s_nxt.mins = s_r.mins + 6'd1;
                end else begin
                    s_nxt.mins = '0;
                    if (s_r.hours != 5'(HOUR_MAX)) begin
                        s_nxt.hours = s_r.hours + 5'd1;
                    end else begin
                        s_nxt.hours = '0;
                        s_nxt.days  = s_r.days + 16'd1;
                    end
                end
            end
        end else begin
            s_nxt.tick = s_r.tick + 32'd1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Clock enable low freezes every counter and the timer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= state_type'(CNT_RST);
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register
    assign rd_data   = s_r.rd_data;
    assign addr_used = s_r.addr_used;
    assign up_days   = s_r.days;
    assign up_hours  = s_r.hours;
    assign up_mins   = s_r.mins;
    assign up_secs   = s_r.secs;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    logic live;
    assign live = ce && !clr_req;

    // Counter idx steps by exactly one after the event
    property p_inc(ev, idx);
        ev && live |=> s_r.cnt[idx] == $past(s_r.cnt[idx]) + ONE;
    endproperty

    // Counter idx holds still when the event is absent
    property p_hold(ev, idx);
        !ev && live |=> s_r.cnt[idx] == $past(s_r.cnt[idx]);
    endproperty

    a_octet_sum: assert property (
        rx_done && live |=> s_r.cnt[C_OCT]
            == $past(s_r.cnt[C_OCT]) + CNT_W'($past(rx_len)))
        else $error("octet count did not add frame length");

    a_bin_small: assert property (
        p_inc(rx_done && rx_len < LEN_W'(LEN_MIN), C_LT64))
        else $error("short frame bin missed");

    a_bin_exact: assert property (
        p_inc(rx_done && rx_len == LEN_W'(LEN_MIN), C_64))
        else $error("64 octet bin missed");

    a_bin_edge: assert property (
        p_hold(rx_done && rx_len >= LEN_W'(LEN_B1023 + 1)
            && rx_len <= LEN_W'(LEN_STD_MAX), C_1518))
        else $error("1024-1518 bin moved without such a frame");

    a_bin_tagged: assert property (
        p_inc(rx_done && rx_len > LEN_W'(LEN_STD_MAX)
            && rx_len <= LEN_W'(LEN_TAG_MAX), C_1522))
        else $error("1519-1522 bin missed");

    a_oversize_ok: assert property (
        p_hold(rx_done && rx_len > LEN_W'(LEN_TAG_MAX)
            && well_formed, C_OVER))
        else $error("oversize counted a bad or short frame");

    a_good_err: assert property (
        rx_done && live |=> (s_r.cnt[C_RX_GOOD]
            - $past(s_r.cnt[C_RX_GOOD])) + (s_r.cnt[C_RX_ERR]
            - $past(s_r.cnt[C_RX_ERR])) == ONE)
        else $error("frame not counted once as good or error");

    a_mcast_excl: assert property (
        p_hold(rx_done && rx_good && rx_dst_group
            && !rx_dst_bcast, C_MCAST))
        else $error("multicast counted broadcast or bad frame");

    a_bcast_rx: assert property (
        p_inc(rx_done && rx_good && rx_dst_bcast, C_BCAST))
        else $error("broadcast receive missed");

    a_jabber_cnt: assert property (
        p_inc(rx_done && rx_fcs_bad
            && rx_len > LEN_W'(LEN_STD_MAX), C_JABBER))
        else $error("jabber missed");

    a_align_fcs: assert property (
        rx_done && live && std_len && rx_fcs_bad |=>
            (s_r.cnt[C_ALIGN] != $past(s_r.cnt[C_ALIGN]))
            != (s_r.cnt[C_FCS] != $past(s_r.cnt[C_FCS])))
        else $error("bad FCS frame not in exactly one class");

    a_tx_result: assert property (
        p_inc(tx_done && !tx_ok, C_TX_ERR))
        else $error("transmit error missed");

    a_coll_sum: assert property (
        tx_coll && live |=> s_r.cnt[C_COLL]
            == $past(s_r.cnt[C_COLL]) + CNT_W'($past(tx_coll_num)))
        else $error("collisions not accumulated");

    a_addr_up: assert property (
        ce && addr_add && !addr_del && s_r.addr_used != '1
            |=> s_r.addr_used == $past(s_r.addr_used) + ADDR_W'(1))
        else $error("address occupancy did not rise");

    a_sec_step: assert property (
        live && s_r.tick == TICK_LAST && s_r.secs < 6'(SEC_MAX)
            |=> s_r.secs == $past(s_r.secs) + 6'd1 && s_r.tick == '0)
        else $error("seconds did not advance on tick");

    a_clear_all: assert property (
        ce && clr_req && !rx_done && !tx_done |=>
            s_r.cnt[C_RX_GOOD] == '0 && s_r.cnt[C_TX_GOOD] == '0
            && s_r.secs == '0 && s_r.tick == '0)
        else $error("clear left counters or time");

    c_jabber: cover property (
        rx_done && live && rx_fcs_bad && rx_len > LEN_W'(LEN_STD_MAX));
    c_clear_hit: cover property (ce && clr_req && rx_done);
    c_min_roll: cover property (live && s_r.tick == TICK_LAST
        && s_r.secs == 6'(SEC_MAX));
    c_tx_both: cover property (tx_done && tx_bcast_req && tx_coll);

endmodule

`default_nettype wire

/* File: mac_path_model.sv */
// Behavioural model of the MAC receive and transmit paths feeding the statistics block
`timescale 1ns/1ns
`default_nettype none

module mac_path_model
    import port_stats_pkg::*;
(
    input  wire logic        clock,
    output logic             rx_done,
    output logic [15:0]      rx_len,
    output logic             rx_fcs_bad,
    output logic             rx_part_octet,
    output logic             rx_sym_err,
    output logic             rx_dst_group,
    output logic             rx_dst_bcast,
    output logic             rx_to_upper,
    output logic             rx_overrun,
    output logic             tx_done,
    output logic             tx_ok,
    output logic             tx_coll,
    output logic [4:0]       tx_coll_num,
    output logic             tx_bcast_req
);
    // ------------------------------------------------------------
    // Idle state of every path
    // ------------------------------------------------------------
    initial begin
        {rx_done, rx_fcs_bad, rx_part_octet, rx_sym_err} = '0;
        {rx_dst_group, rx_dst_bcast, rx_to_upper, rx_overrun} = '0;
        {tx_done, tx_ok, tx_coll, tx_bcast_req} = '0;
        rx_len      = '0;
        tx_coll_num = '0;
    end

    // ------------------------------------------------------------
    // One received frame ends; qualifiers valid only with the pulse
    // ------------------------------------------------------------
    task automatic rx_frame(input logic [15:0] len, input logic fcs, part, sym, grp, bc, up);
        @(posedge clock);
        rx_done       <= 1'b1;
        rx_len        <= len;
        rx_fcs_bad    <= fcs;
        rx_part_octet <= part;
        rx_sym_err    <= sym;
        rx_dst_group  <= grp | bc;  // Broadcast address always has the group bit
        rx_dst_bcast  <= bc;
        rx_to_upper   <= up;
        @(posedge clock);
        rx_done <= 1'b0;
        // Released qualifiers flip so a stale value can never be counted
        rx_len  <= ~len;
        {rx_fcs_bad, rx_part_octet, rx_sym_err} <= ~{fcs, part, sym};
        {rx_dst_group, rx_dst_bcast, rx_to_upper} <= ~{grp | bc, bc, up};
    endtask

    // ------------------------------------------------------------
    // Transmit completion, collisions, broadcast request, overrun drop
    // ------------------------------------------------------------
    task automatic tx_event(input logic done, ok, coll, input logic [4:0] num, input logic breq, ovr);
        @(posedge clock);
        tx_done      <= done;
        tx_ok        <= ok;
        tx_coll      <= coll;
        tx_coll_num  <= num;
        tx_bcast_req <= breq;
        rx_overrun   <= ovr;
        @(posedge clock);
        {tx_done, tx_coll, tx_bcast_req, rx_overrun} <= '0;
        tx_ok       <= ~ok;
        tx_coll_num <= ~num;
    endtask
endmodule

`default_nettype wire

/* File: ethernet_port_statistics_bench.sv */
// Self-checking testbench of the per-port statistics block
`timescale 1ns/1ns
`default_nettype none

module ethernet_port_statistics_bench;
    import port_stats_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int SEC = 10;  // Short second keeps the timer test brief
    logic              clock, rst_b, ce, addr_add, addr_del, clr_req;
    logic              rx_done, rx_fcs_bad, rx_part_octet, rx_sym_err, rx_dst_group;
    logic              rx_dst_bcast, rx_to_upper, rx_overrun, tx_done, tx_ok, tx_coll, tx_bcast_req;
    logic [15:0]       rx_len, up_days;
    logic [4:0]        tx_coll_num, up_hours;
    logic [SEL_W-1:0]  rd_sel;
    logic [31:0]       rd_data;
    logic [13:0]       addr_used;
    logic [5:0]        up_mins, up_secs;
    logic [31:0]       exp_cnt [NUM_CNT];
    int                fails, n_tests, cycles;

    port_stats #(.SEC_CYCLES(SEC)) DUT (.clock(clock), .rst_b(rst_b), .ce(ce), .rx_done(rx_done),
        .rx_len(rx_len), .rx_fcs_bad(rx_fcs_bad), .rx_part_octet(rx_part_octet), .rx_sym_err(rx_sym_err),
        .rx_dst_group(rx_dst_group), .rx_dst_bcast(rx_dst_bcast), .rx_to_upper(rx_to_upper),
        .rx_overrun(rx_overrun), .tx_done(tx_done), .tx_ok(tx_ok), .tx_coll(tx_coll),
        .tx_coll_num(tx_coll_num), .tx_bcast_req(tx_bcast_req), .addr_add(addr_add), .addr_del(addr_del),
        .clr_req(clr_req), .rd_sel(rd_sel), .rd_data(rd_data), .addr_used(addr_used), .up_days(up_days),
        .up_hours(up_hours), .up_mins(up_mins), .up_secs(up_secs));

    mac_path_model partner (.clock(clock), .rx_done(rx_done), .rx_len(rx_len), .rx_fcs_bad(rx_fcs_bad),
        .rx_part_octet(rx_part_octet), .rx_sym_err(rx_sym_err), .rx_dst_group(rx_dst_group),
        .rx_dst_bcast(rx_dst_bcast), .rx_to_upper(rx_to_upper), .rx_overrun(rx_overrun), .tx_done(tx_done),
        .tx_ok(tx_ok), .tx_coll(tx_coll), .tx_coll_num(tx_coll_num), .tx_bcast_req(tx_bcast_req));

    // Clock at 20 MHz
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Hang guard; the whole run needs about 37000 cycles, most of it the hour carry
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Read one counter; rd_data answers at the edge after rd_sel is taken
    task automatic rd(input int idx, input logic [31:0] exp);
        @(posedge clock) rd_sel <= SEL_W'(idx);
        @(posedge clock);
        #1 cmp($sformatf("counter %0d", idx), exp, rd_data);
    endtask

    task automatic check_all();
        for (int i = 0; i < NUM_CNT; i++) begin
            rd(i, exp_cnt[i]);
        end
    endtask

    // Send a frame and book what every counter should gain
    task automatic frame(input int len, input logic fcs, part, sym, grp, bc, up);
        logic good;
        good = !fcs && !sym && len >= LEN_MIN && len <= LEN_TAG_MAX;
        partner.rx_frame(16'(len), fcs, part, sym, grp, bc, up);
        exp_cnt[C_OCT] += 32'(len);
        if (len < LEN_MIN) begin
            exp_cnt[C_LT64]++;
            exp_cnt[C_FRAG]++;
        end
        else if (len == LEN_MIN) exp_cnt[C_64]++;
        else if (len <= LEN_B127) exp_cnt[C_127]++;
        else if (len <= LEN_B255) exp_cnt[C_255]++;
        else if (len <= LEN_B511) exp_cnt[C_511]++;
        else if (len <= LEN_B1023) exp_cnt[C_1023]++;
        else if (len <= LEN_STD_MAX) exp_cnt[C_1518]++;
        else if (len <= LEN_TAG_MAX) exp_cnt[C_1522]++;
        else if (!fcs && !sym) exp_cnt[C_OVER]++;
        if (good) begin
            exp_cnt[C_RX_GOOD]++;
            if (!grp && !bc && up) exp_cnt[C_UCAST]++;
            if (grp && !bc) exp_cnt[C_MCAST]++;
            if (bc) exp_cnt[C_BCAST]++;
        end
        else exp_cnt[C_RX_ERR]++;
        if (len > LEN_STD_MAX && fcs) exp_cnt[C_JABBER]++;
        if (len >= LEN_MIN && len <= LEN_STD_MAX && fcs) begin
            if (part) exp_cnt[C_ALIGN]++;
            else exp_cnt[C_FCS]++;
        end
    endtask

    task automatic addr_ev(input logic a, d);
        @(posedge clock);
        addr_add <= a;
        addr_del <= d;
        @(posedge clock);
        addr_add <= 1'b0;
        addr_del <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        @(posedge clock) rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        #1 cmp("up_secs", 32'h0, 32'(up_secs));
        cmp("addr_used", 32'h0, 32'(addr_used));
        @(posedge clock) rst_b <= 1'b1;
        foreach (exp_cnt[i]) exp_cnt[i] = '0;
        check_all();
        rd(31, 32'h0);  // Unused index reads zero
    endtask

    // Every length edge, back to back
    task automatic t_bins();
        int lens [15] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519, 1522, 1523};
        foreach (lens[i]) frame(lens[i], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        check_all();
    endtask

    task automatic t_errors();
        frame(100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(100, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(1518, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(1519, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(1600, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(1600, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        frame(40, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(1520, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        frame(64, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        frame(300, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        partner.tx_event(1'b0, 1'b0, 1'b0, 5'h00, 1'b0, 1'b1);
        exp_cnt[C_OVERRUN]++;
        check_all();
    endtask

    task automatic t_tx();
        partner.tx_event(1'b1, 1'b1, 1'b0, 5'h00, 1'b1, 1'b0);
        partner.tx_event(1'b1, 1'b0, 1'b1, 5'h1f, 1'b1, 1'b0);
        partner.tx_event(1'b0, 1'b0, 1'b1, 5'h03, 1'b0, 1'b0);
        exp_cnt[C_TX_GOOD] += 32'h1;
        exp_cnt[C_TX_ERR]  += 32'h1;
        exp_cnt[C_COLL]    += 32'h22;
        exp_cnt[C_TX_BCAST] += 32'h2;
        check_all();
    endtask

    // Empty table stays at zero, add with delete cancels
    task automatic t_addr();
        addr_ev(1'b0, 1'b1);
        repeat (3) addr_ev(1'b1, 1'b0);
        addr_ev(1'b1, 1'b1);
        addr_ev(1'b0, 1'b1);
        repeat (2) @(posedge clock);
        #1 cmp("addr_used", 32'h2, 32'(addr_used));
    endtask

    // A frame while disabled must be lost
    task automatic t_ce();
        @(posedge clock) ce <= 1'b0;
        partner.rx_frame(16'd64, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge clock) ce <= 1'b1;
        check_all();
    endtask

    // Clear with a frame in the same cycle, then watch the elapsed time restart
    task automatic t_clear();
        foreach (exp_cnt[i]) exp_cnt[i] = '0;
        fork
            frame(64, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
            begin
                @(posedge clock) clr_req <= 1'b1;
                @(posedge clock) clr_req <= 1'b0;
            end
        join
        repeat (SEC - 1) @(posedge clock);
        #1 cmp("up_secs", 32'h0, 32'(up_secs));
        @(posedge clock);
        #1 cmp("up_secs", 32'h1, 32'(up_secs));
        repeat (59 * SEC) @(posedge clock);
        #1 cmp("up_mins", 32'h1, 32'(up_mins));
        cmp("up_secs", 32'h0, 32'(up_secs));
        repeat (3540 * SEC) @(posedge clock);
        #1 cmp("up_hours", 32'h1, 32'(up_hours));
        cmp("up_mins", 32'h0, 32'(up_mins));
        cmp("up_days", 32'h0, 32'(up_days));
        cmp("addr_used", 32'h2, 32'(addr_used));
        check_all();
        // A clear with no event in its cycle leaves every counter and the time at zero
        @(posedge clock) clr_req <= 1'b1;
        @(posedge clock) clr_req <= 1'b0;
        foreach (exp_cnt[i]) exp_cnt[i] = '0;
        #1 cmp("up_hours", 32'h0, 32'(up_hours));
        check_all();
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_b, addr_add, addr_del, clr_req} = '0;
        ce     = 1'b1;
        rd_sel = '0;
        t_reset();
        t_bins();
        t_errors();
        t_tx();
        t_addr();
        t_ce();
        t_clear();
        t_reset();
        give_verdict();
    end
endmodule

`default_nettype wire
